//--- logic/usrt_defs.svh
`ifndef USRT_DEFS_SVH
`define USRT_DEFS_SVH

// register offsets on the plain register port
`define OFS_CTRL 4'h0
`define OFS_COND1 4'h1
`define OFS_COND2 4'h2
`define OFS_SAMPLE 4'h3
`define OFS_NEWSMP 4'h4
`define OFS_CLKLINE 4'h5
`define OFS_DATLINE 4'h6
`define OFS_IRQSTAT 4'h7
`define OFS_IRQMASK 4'h8

// control register fields
`define CTRL_ENABLE 0
`define CTRL_STR_ALWAYS 1
`define CTRL_STR_COND 2
`define CTRL_STR_ACTIVE 3

// interrupt status and mask fields
`define COND_ONE_INTERRUPT 0
`define COND_TWO_INTERRUPT 1
`define IRQ_SAMPLE 2

// reset values
`define RST_FLAG 1'b0
`define RST_BYTE 8'h00
`define RST_LINE 1'b1

`endif

//--- logic/usrt_pkg.sv
package usrt_pkg;

   typedef struct packed {
      logic clk;
      logic dat;
   } line_pair_t;

   typedef struct packed {
      logic str_cond;
      logic str_always;
      logic en;
   } ctrl_t;

   typedef struct packed {
      logic sample;
      logic cond2;
      logic cond1;
   } event_t;

endpackage

//--- logic/line_sync.sv
`timescale 1ns/100ps
`default_nettype none

`include "usrt_defs.svh"

module line_sync #(
   parameter int W = 2
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);

   logic [W-1:0] meta;
   logic [W-1:0] stable;
   logic [W-1:0] prev;

   // idle lines are pulled up, so reset to one to avoid a false edge
   genvar g;
   for (g = 0; g < W; g++) begin : gen_bit
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            meta[g] <= `RST_LINE;
            stable[g] <= `RST_LINE;
            prev[g] <= `RST_LINE;
         end else begin
            meta[g] <= pin_i[g];
            stable[g] <= meta[g];
            prev[g] <= stable[g];
         end
      end
      assign level_o[g] = stable[g];
      assign rise_o[g] = stable[g] & ~prev[g];
      assign fall_o[g] = ~stable[g] & prev[g];
   end

endmodule

`default_nettype wire

//--- logic/usrt_serial_assist.sv
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

`include "usrt_defs.svh"

module usrt_serial_assist (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic serial_clock_line_i,
   output logic serial_clock_line_o,
   output logic serial_clock_line_oe_o,
   input wire logic serial_data_line_i,
   output logic serial_data_line_o,
   output logic serial_data_line_oe_o,
   output logic cond_one_interrupt_o,
   output logic cond_two_interrupt_o,
   output logic irq_o
);

   logic [1:0] rst_pipe;
   logic rst_n;

   usrt_pkg::line_pair_t lvl;
   usrt_pkg::line_pair_t rise;
   usrt_pkg::line_pair_t fall;

   usrt_pkg::ctrl_t ctrl;
   usrt_pkg::ctrl_t next_ctrl;
   logic stretch_active_flag;
   logic next_stretch_active_flag;
   logic cond_one_flag;
   logic next_cond_one_flag;
   logic cond_two_flag;
   logic next_cond_two_flag;
   logic sampled_data;
   logic next_sampled_data;
   logic new_sample_flag;
   logic next_new_sample_flag;
   logic clk_drive;
   logic next_clk_drive;
   logic dat_drive;
   logic next_dat_drive;
   usrt_pkg::event_t irq_stat;
   usrt_pkg::event_t next_irq_stat;
   usrt_pkg::event_t irq_mask;
   usrt_pkg::event_t next_irq_mask;
   logic cond_one_pulse;
   logic next_cond_one_pulse;
   logic cond_two_pulse;
   logic next_cond_two_pulse;
   logic [7:0] next_rdata;

   usrt_pkg::event_t hit;
   logic stretch_hit;
   logic wr_ctrl;
   logic wr_cond1;
   logic wr_cond2;
   logic wr_sample;
   logic rd_sample;
   logic wr_clkline;
   logic wr_datline;
   logic wr_stat;
   logic wr_mask;

   // reset released through two flops so release is clean on clk_i
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   line_sync #(
      .W(2)
   ) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .pin_i({serial_clock_line_i, serial_data_line_i}),
      .level_o(lvl),
      .rise_o(rise),
      .fall_o(fall)
   );

   // address decode
   assign wr_ctrl = wr_i && (addr_i == `OFS_CTRL);
   assign wr_cond1 = wr_i && (addr_i == `OFS_COND1);
   assign wr_cond2 = wr_i && (addr_i == `OFS_COND2);
   assign wr_sample = wr_i && (addr_i == `OFS_SAMPLE);
   assign rd_sample = rd_i && (addr_i == `OFS_SAMPLE);
   assign wr_clkline = wr_i && (addr_i == `OFS_CLKLINE);
   assign wr_datline = wr_i && (addr_i == `OFS_DATLINE);
   assign wr_stat = wr_i && (addr_i == `OFS_IRQSTAT);
   assign wr_mask = wr_i && (addr_i == `OFS_IRQMASK);

   // line events, all gated by the enable
   assign hit.cond1 = ctrl.en && fall.dat && lvl.clk;
   assign hit.cond2 = ctrl.en && rise.dat && lvl.clk;
   assign hit.sample = ctrl.en && rise.clk;
   // cond1 is the registered flag, so a cond1 in this very cycle waits
   assign stretch_hit = ctrl.en && fall.clk &&
                        (ctrl.str_always || (ctrl.str_cond && cond_one_flag));

   // set wins over clear on every hardware flag
   always_comb begin
      next_ctrl = ctrl;
      next_stretch_active_flag = stretch_active_flag;
      next_cond_one_flag = cond_one_flag;
      next_cond_two_flag = cond_two_flag;
      next_sampled_data = sampled_data;
      next_new_sample_flag = new_sample_flag;
      next_clk_drive = clk_drive;
      next_dat_drive = dat_drive;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      next_cond_one_pulse = hit.cond1;
      next_cond_two_pulse = hit.cond2;
      if (wr_ctrl) begin
         next_ctrl.en = wdata_i[`CTRL_ENABLE];
         next_ctrl.str_always = wdata_i[`CTRL_STR_ALWAYS];
         next_ctrl.str_cond = wdata_i[`CTRL_STR_COND];
      end
      if (wr_sample) begin
         next_stretch_active_flag = 1'b0;
      end
      if (stretch_hit) begin
         next_stretch_active_flag = 1'b1;
      end
      if (wr_cond1) begin
         next_cond_one_flag = 1'b0;
      end
      if (hit.cond1) begin
         next_cond_one_flag = 1'b1;
      end
      if (wr_cond2) begin
         next_cond_two_flag = 1'b0;
      end
      if (hit.cond2) begin
         next_cond_two_flag = 1'b1;
      end
      if (rd_sample) begin
         next_new_sample_flag = 1'b0;
      end
      if (hit.sample) begin
         next_sampled_data = lvl.dat;
         next_new_sample_flag = 1'b1;
      end
      if (wr_clkline) begin
         next_clk_drive = wdata_i[0];
      end
      if (wr_datline) begin
         next_dat_drive = wdata_i[0];
      end
      if (wr_mask) begin
         next_irq_mask = wdata_i[2:0];
      end
      if (wr_stat) begin
         next_irq_stat = irq_stat & ~usrt_pkg::event_t'(wdata_i[2:0]);
      end
      next_irq_stat = next_irq_stat | hit;
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= '0;
         stretch_active_flag <= `RST_FLAG;
         cond_one_flag <= `RST_FLAG;
         cond_two_flag <= `RST_FLAG;
         sampled_data <= `RST_FLAG;
         new_sample_flag <= `RST_FLAG;
         clk_drive <= `RST_LINE;
         dat_drive <= `RST_LINE;
         irq_mask <= '0;
         irq_stat <= '0;
         cond_one_pulse <= `RST_FLAG;
         cond_two_pulse <= `RST_FLAG;
      end else begin
         ctrl <= next_ctrl;
         stretch_active_flag <= next_stretch_active_flag;
         cond_one_flag <= next_cond_one_flag;
         cond_two_flag <= next_cond_two_flag;
         sampled_data <= next_sampled_data;
         new_sample_flag <= next_new_sample_flag;
         clk_drive <= next_clk_drive;
         dat_drive <= next_dat_drive;
         irq_mask <= next_irq_mask;
         irq_stat <= next_irq_stat;
         cond_one_pulse <= next_cond_one_pulse;
         cond_two_pulse <= next_cond_two_pulse;
      end
   end

   // read port, data valid the cycle after the strobe, unmapped reads zero
   always_comb begin
      next_rdata = `RST_BYTE;
      if (rd_i) begin
         case (addr_i)
            `OFS_CTRL: begin
               next_rdata[`CTRL_ENABLE] = ctrl.en;
               next_rdata[`CTRL_STR_ALWAYS] = ctrl.str_always;
               next_rdata[`CTRL_STR_COND] = ctrl.str_cond;
               next_rdata[`CTRL_STR_ACTIVE] = stretch_active_flag;
            end
            `OFS_COND1: next_rdata[0] = cond_one_flag;
            `OFS_COND2: next_rdata[0] = cond_two_flag;
            `OFS_SAMPLE: next_rdata[0] = sampled_data;
            `OFS_NEWSMP: next_rdata[0] = new_sample_flag;
            `OFS_CLKLINE: next_rdata[0] = lvl.clk;
            `OFS_DATLINE: next_rdata[0] = lvl.dat;
            `OFS_IRQSTAT: next_rdata[2:0] = irq_stat;
            `OFS_IRQMASK: next_rdata[2:0] = irq_mask;
            default: next_rdata = `RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o <= `RST_BYTE;
      end else begin
         rdata_o <= next_rdata;
      end
   end

   // open drain: only ever drive low, and only while enabled
   assign serial_clock_line_o = 1'b0;
   assign serial_data_line_o = 1'b0;
   assign serial_clock_line_oe_o = ctrl.en && (!clk_drive || stretch_active_flag);
   assign serial_data_line_oe_o = ctrl.en && !dat_drive;
   assign cond_one_interrupt_o = cond_one_pulse;
   assign cond_two_interrupt_o = cond_two_pulse;
   assign irq_o = |(irq_stat & irq_mask);

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n);

   idle_lines_a: assert property (
      !ctrl.en |-> !serial_clock_line_oe_o && !serial_data_line_oe_o)
      else $error("lines driven while disabled");

   cond_one_set_a: assert property (
      (ctrl.en && fall.dat && lvl.clk) |=> cond_one_flag)
      else $error("cond1 not set on data fall with clock high");

   cond_two_set_a: assert property (
      (ctrl.en && rise.dat && lvl.clk) |=> cond_two_flag)
      else $error("cond2 not set on data rise with clock high");

   cond_clear_a: assert property (
      (wr_cond1 && !hit.cond1) |=> !cond_one_flag)
      else $error("cond1 not cleared by write");

   cond_irq_a: assert property (
      hit.cond2 |=> cond_two_interrupt_o && cond_two_flag ##1 !cond_two_interrupt_o)
      else $error("cond2 interrupt not a single pulse");

   stretch_hold_a: assert property (
      (ctrl.en && ctrl.str_always && fall.clk && !wr_sample && !wr_ctrl)
      |=> stretch_active_flag && serial_clock_line_oe_o)
      else $error("clock not held low after fall");

   stretch_cond_a: assert property (
      (ctrl.en && !ctrl.str_always && ctrl.str_cond && fall.clk && !stretch_active_flag)
      |=> stretch_active_flag == $past(cond_one_flag))
      else $error("conditional stretch wrong");

   stretch_release_a: assert property (
      (wr_sample && !stretch_hit) |=> !stretch_active_flag)
      else $error("stretch not released by sample write");

   sample_capture_a: assert property (
      hit.sample |=> sampled_data == $past(lvl.dat) && new_sample_flag)
      else $error("sample not captured on clock rise");

   new_sample_clear_a: assert property (
      (rd_sample && !hit.sample) |=> !new_sample_flag)
      else $error("new sample flag not cleared by read");

   upper_zero_a: assert property (
      $past(rd_i) |-> rdata_o[7:4] == 4'h0)
      else $error("unused bits read nonzero");

   line_read_a: assert property (
      (rd_i && addr_i == `OFS_CLKLINE) |=> rdata_o[0] == $past(lvl.clk))
      else $error("clock line read not pin level");

   single_edge_a: assert property (
      rise.clk |=> !rise.clk)
      else $error("clock edge seen twice");

   irq_level_a: assert property (
      (|(irq_stat & irq_mask)) |-> irq_o)
      else $error("interrupt output low with pending event");

   cond_seen_c: cover property (hit.cond1 ##[1:200] hit.cond2);
   stretch_cycle_c: cover property (stretch_hit ##[1:200] wr_sample);
   sample_read_c: cover property (hit.sample ##[1:200] rd_sample);

endmodule

`default_nettype wire

//--- bench/serial_peer.sv
`timescale 1ns/100ps
`default_nettype none

module serial_peer (
   input wire logic dut_clk_oe_i,
   input wire logic dut_dat_oe_i,
   output logic clk_line_o,
   output logic dat_line_o
);
   logic clk_rel;
   logic dat_rel;

   initial begin
      clk_rel = 1'b1;
      dat_rel = 1'b1;
   end

   // pull-ups: a released line floats high, never the last value
   assign clk_line_o = clk_rel & !dut_clk_oe_i;
   assign dat_line_o = dat_rel & !dut_dat_oe_i;

   // one bit: waits out a stretch, data moves while clock low
   task automatic tick(input logic d);
      wait (clk_line_o === 1'b1);
      clk_rel = 1'b0;
      #31;
      dat_rel = d;
      #31.5;
      clk_rel = 1'b1;
      #62.5;
   endtask

   // data edge while clock high
   task automatic cond(input logic d);
      wait (clk_line_o === 1'b1);
      dat_rel = d;
      #62.5;
   endtask
endmodule

`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

`include "usrt_defs.svh"

module tb_top;
   logic clk;
   logic nrst;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic clk_oe, dat_oe, clk_line, dat_line, int1, int2, irq;
   logic clk_o, dat_o;
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int n1 = 0;
   int n2 = 0;

   always #4 clk = ~clk;

   usrt_serial_assist dut_u (
      .clk_i(clk),
      .nrst_i(nrst),
      .addr_i(addr),
      .wdata_i(wdata),
      .wr_i(wr),
      .rd_i(rd),
      .rdata_o(rdata),
      .serial_clock_line_i(clk_line),
      .serial_clock_line_o(clk_o),
      .serial_clock_line_oe_o(clk_oe),
      .serial_data_line_i(dat_line),
      .serial_data_line_o(dat_o),
      .serial_data_line_oe_o(dat_oe),
      .cond_one_interrupt_o(int1),
      .cond_two_interrupt_o(int2),
      .irq_o(irq)
   );

   serial_peer peer_u (
      .dut_clk_oe_i(clk_oe),
      .dut_dat_oe_i(dat_oe),
      .clk_line_o(clk_line),
      .dat_line_o(dat_line)
   );

   // pulse counters catch a doubled or missing interrupt
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (int1 === 1'b1)
         n1 <= n1 + 1;
      if (int2 === 1'b1)
         n2 <= n2 + 1;
      if (cycles == 5000) begin
         n_errors = n_errors + 1;
         results();
      end
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(what, exp, rdata);
   endtask

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      // offset 3 is skipped, though sampled data resets to zero
      for (int i = 0; i < 16; i++) begin
         if (i != 3)
            rd_chk("reset value", 4'(i), (i == 5 || i == 6) ? 8'h01 : 8'h00);
      end
      done("reset");
      peer_u.cond(1'b0);
      rd_chk("cond1 disabled", `OFS_COND1, 8'h00);
      chk("clock oe disabled", 8'h00, {7'h00, clk_oe});
      peer_u.cond(1'b1);
      wr_reg(`OFS_CTRL, 8'h09);
      rd_chk("ctrl", `OFS_CTRL, 8'h01);
      wr_reg(`OFS_IRQMASK, 8'h07);
      done("disabled");
      peer_u.cond(1'b0);
      rd_chk("cond1", `OFS_COND1, 8'h01);
      chk("cond1 pulses", 8'h01, 8'(n1));
      rd_chk("data pin", `OFS_DATLINE, 8'h00);
      chk("irq", 8'h01, {7'h00, irq});
      wr_reg(`OFS_COND1, 8'hff);
      rd_chk("cond1 cleared", `OFS_COND1, 8'h00);
      wr_reg(`OFS_IRQSTAT, 8'h01);
      rd_chk("status", `OFS_IRQSTAT, 8'h00);
      chk("irq low", 8'h00, {7'h00, irq});
      peer_u.cond(1'b1);
      rd_chk("cond2", `OFS_COND2, 8'h01);
      chk("cond2 pulses", 8'h01, 8'(n2));
      rd_chk("status", `OFS_IRQSTAT, 8'h02);
      wr_reg(`OFS_IRQSTAT, 8'h02);
      done("conditions");
      peer_u.tick(1'b1);
      rd_chk("new sample", `OFS_NEWSMP, 8'h01);
      rd_chk("sample", `OFS_SAMPLE, 8'h01);
      rd_chk("new sample read", `OFS_NEWSMP, 8'h00);
      peer_u.tick(1'b0);
      rd_chk("sample", `OFS_SAMPLE, 8'h00);
      rd_chk("cond1 low clock", `OFS_COND1, 8'h00);
      rd_chk("status", `OFS_IRQSTAT, 8'h04);
      wr_reg(`OFS_IRQSTAT, 8'h07);
      done("sampling");
      wr_reg(`OFS_CTRL, 8'h03);
      peer_u.tick(1'b1);
      rd_chk("stretch flag", `OFS_CTRL, 8'h0b);
      rd_chk("clock held", `OFS_CLKLINE, 8'h00);
      wr_reg(`OFS_SAMPLE, 8'h00);
      rd_chk("stretch off", `OFS_CTRL, 8'h03);
      rd_chk("clock free", `OFS_CLKLINE, 8'h01);
      done("stretch always");
      wr_reg(`OFS_CTRL, 8'h05);
      wr_reg(`OFS_COND1, 8'h00);
      peer_u.tick(1'b1);
      rd_chk("no stretch", `OFS_CTRL, 8'h05);
      peer_u.cond(1'b0);
      peer_u.tick(1'b1);
      rd_chk("cond stretch", `OFS_CTRL, 8'h0d);
      wr_reg(`OFS_SAMPLE, 8'h5a);
      rd_chk("cond release", `OFS_CTRL, 8'h05);
      done("stretch after cond1");
      wr_reg(`OFS_COND1, 8'h00);
      wr_reg(`OFS_COND2, 8'h00);
      rd_chk("cond2 cleared", `OFS_COND2, 8'h00);
      // own data drive falls while clock high, so it must raise cond1 too
      wr_reg(`OFS_DATLINE, 8'h00);
      repeat (4) @(posedge clk);
      chk("data oe", 8'h01, {7'h00, dat_oe});
      chk("lines out low", 8'h00, {6'h00, clk_o, dat_o});
      rd_chk("data pin driven", `OFS_DATLINE, 8'h00);
      rd_chk("cond1 own drive", `OFS_COND1, 8'h01);
      wr_reg(`OFS_CTRL, 8'h00);
      repeat (4) @(posedge clk);
      chk("data oe disabled", 8'h00, {7'h00, dat_oe});
      rd_chk("data pin free", `OFS_DATLINE, 8'h01);
      rd_chk("cond2 disabled", `OFS_COND2, 8'h00);
      done("line drive");
      results();
   end
endmodule

`default_nettype wire
